// ===== hdl/char_lcd_pkg.sv
// Shared constants and carrier types of the character display instruction sequencer.
// Assumes one clock domain and software access over APB with 32-bit aligned words.
`default_nettype none
package char_lcd_pkg;
  // Text store geometry and codes.
  localparam int         RAM_DEPTH   = 80;
  localparam logic [6:0] LAST_INDEX  = 7'h4f;
  localparam logic [6:0] LINE_LAST   = 7'h27;
  localparam logic [6:0] LINE_LEN    = 7'h28;
  localparam logic [6:0] LINE2_BASE  = 7'h40;
  localparam logic [7:0] BLANK_CODE  = 8'h20;

  // Instruction field positions.
  localparam int FS_WIDTH_BIT   = 4;
  localparam int FS_LINES_BIT   = 3;
  localparam int DC_DISPLAY_BIT = 2;
  localparam int DC_CURSOR_BIT  = 1;
  localparam int DC_BLINK_BIT   = 0;
  localparam int EM_INC_BIT     = 1;
  localparam int EM_SHIFT_BIT   = 0;
  localparam int SH_DISPLAY_BIT = 3;
  localparam int SH_RIGHT_BIT   = 2;

  // Reset values of the mode flags.
  localparam logic RST_DISPLAY_ON  = 1'b0;
  localparam logic RST_CURSOR_ON   = 1'b0;
  localparam logic RST_BLINK       = 1'b0;
  localparam logic RST_BYTE_WIDE   = 1'b1;
  localparam logic RST_TWO_LINE    = 1'b0;
  localparam logic RST_INCREMENT   = 1'b1;
  localparam logic RST_ENTRY_SHIFT = 1'b0;

  // Register byte offsets.
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_POSITION  = 8'h04;
  localparam logic [7:0] REG_VIEW_POS  = 8'h08;
  localparam logic [7:0] REG_VIEW_DATA = 8'h0c;
  localparam logic [7:0] REG_CONTROL   = 8'h10;

  // Field positions inside the registers.
  localparam int CTRL_RESTART_BIT = 0;
  localparam int POS_OFFSET_LSB   = 8;
  localparam int STAT_PENDING_BIT = 7;
  localparam int STAT_BLANK_BIT   = 8;

  // One latched host access.
  typedef struct packed {
    logic       cds;
    logic       read;
    logic [7:0] data;
  } host_access_t;

  // Mode flags set by instructions.
  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink;
    logic byte_wide;
    logic two_line;
    logic increment;
    logic entry_shift;
  } mode_t;
endpackage : char_lcd_pkg
`default_nettype wire

// ===== hdl/wrap_step.sv
// Modulo up/down stepper for a position counter.
// Assumes the limit is the largest legal value; values above it step to zero or down normally.
`default_nettype none
module wrap_step #(
  parameter int W = 7
) (
  input  wire logic [W-1:0] value_in,
  input  wire logic [W-1:0] limit_in,
  input  wire logic         step_in,
  input  wire logic         up_in,
  output logic      [W-1:0] next_out
);
  // Wrap at both ends so a window or cursor never leaves its range.
  always_comb begin
    if (!step_in) begin
      next_out = value_in;
    end else if (up_in) begin
      next_out = (value_in >= limit_in) ? '0 : W'(value_in + 1'b1);
    end else begin
      next_out = (value_in == '0) ? limit_in : W'(value_in - 1'b1);
    end
  end
endmodule : wrap_step
`default_nettype wire

// ===== hdl/strobe_capture.sv
// Latches the parallel host lines at the falling edge of the bus strobe.
// Assumes the host lines are synchronous to clk_in and stable across that edge.
`default_nettype none
module strobe_capture (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        strobe_in,
  input  wire logic                        cds_in,
  input  wire logic                        read_in,
  input  wire logic [7:0]                  data_in,
  output char_lcd_pkg::host_access_t       access_out,
  output logic                             valid_out
);
  logic                       strobe_q;
  logic                       next_strobe_q;
  logic                       next_valid;
  char_lcd_pkg::host_access_t next_access;

  // A high-to-low step of the strobe takes the access.
  always_comb begin
    next_strobe_q = strobe_in;
    next_valid    = strobe_q && !strobe_in;
    next_access   = access_out;
    if (next_valid) begin
      next_access = '{cds: cds_in, read: read_in, data: data_in};
    end
  end

  // Registers only; valid is a one-cycle pulse.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strobe_q   <= 1'b0;
      valid_out  <= 1'b0;
      access_out <= '0;
    end else begin
      strobe_q   <= next_strobe_q;
      valid_out  <= next_valid;
      access_out <= next_access;
    end
  end
endmodule : strobe_capture
`default_nettype wire

// ===== hdl/char_lcd_instruction_sequencer.sv
// Instruction sequencer of a character display controller with an 80-position text store.
// Assumes synchronous host pins, one 50 MHz clock and an APB master for status and readback.
//
// Operation
// - After reset the host interface is byte wide; first write is a full byte.
// - Nibble mode takes two accesses per byte; action follows the second.
// - Function set 001 in bits 7..5; bit 4 high byte wide, low nibble.
// - Display control: bit 3 marker, bit 2 display on, bit 1 cursor on.
// - Entry mode: bit 2 marker; bit 1 set increments address on each write.
// - Entry mode bit 0 set shifts the window on each write; clear keeps it.
// - Data writes store the byte at the current address of the text store.
// - The text store holds 80 character codes, more than are visible.
// - Display shifts move only the window offset, never the stored text.
// - Return home restores the offset so text from address zero shows.
// - In two-line mode the address passes from position 39 to line two.
// - In two-line mode both lines shift together and never mix.
// - After reset the display is off and blank until turned on.
// - Return home sets the address and the window offset to zero; display and cursor flags keep their values.
// - Shift code 00010000 moves only the cursor left, offset unchanged.
`default_nettype none
module char_lcd_instruction_sequencer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        strobe_in,
  input  wire logic        command_data_select_in,
  input  wire logic        read_write_in,
  input  wire logic [7:0]  host_bus_lines_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             display_on_out,
  output logic             cursor_on_out,
  output logic      [6:0]  cursor_index_out,
  output logic      [6:0]  display_offset_out
);
  typedef enum logic {ST_BLANK, ST_RUN} seq_state_t;

  localparam char_lcd_pkg::mode_t MODE_RESET = '{
    display_on:  char_lcd_pkg::RST_DISPLAY_ON,
    cursor_on:   char_lcd_pkg::RST_CURSOR_ON,
    blink:       char_lcd_pkg::RST_BLINK,
    byte_wide:   char_lcd_pkg::RST_BYTE_WIDE,
    two_line:    char_lcd_pkg::RST_TWO_LINE,
    increment:   char_lcd_pkg::RST_INCREMENT,
    entry_shift: char_lcd_pkg::RST_ENTRY_SHIFT
  };

  char_lcd_pkg::host_access_t access;
  logic                       access_valid;
  seq_state_t                 state, next_state;
  char_lcd_pkg::mode_t        mode, next_mode;
  logic [6:0]                 addr_idx, next_addr_idx;
  logic [6:0]                 offset, next_offset;
  logic [6:0]                 clear_idx, next_clear_idx;
  logic [6:0]                 view_pos, next_view_pos;
  logic                       nibble_pending, next_nibble_pending;
  logic [3:0]                 upper_nibble, next_upper_nibble;
  logic [31:0]                next_prdata;
  logic                       next_pready, next_pslverr;
  logic [7:0]                 text_ram [char_lcd_pkg::RAM_DEPTH];
  logic                       ram_we;
  logic [6:0]                 ram_idx;
  logic [7:0]                 ram_wdata;
  logic                       host_go, byte_go;
  logic [7:0]                 cmd_byte;
  logic                       addr_step, addr_up, off_step, off_up;
  logic [6:0]                 addr_stepped, off_stepped, off_limit;
  logic [6:0]                 set_idx, cursor_address, view_idx;
  logic [7:0]                 view_sum;
  logic                       apb_access, apb_commit;

  // The host lines are taken at the strobe falling edge.
  strobe_capture u_capture (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .strobe_in  (strobe_in),
    .cds_in     (command_data_select_in),
    .read_in    (read_write_in),
    .data_in    (host_bus_lines_in),
    .access_out (access),
    .valid_out  (access_valid)
  );

  // The address steps over all 80 positions; in two-line mode index 40 is line two's first.
  wrap_step #(.W(7)) u_addr_step (
    .value_in (addr_idx),
    .limit_in (char_lcd_pkg::LAST_INDEX),
    .step_in  (addr_step),
    .up_in    (addr_up),
    .next_out (addr_stepped)
  );

  // The window offset wraps within one line so both lines move alike.
  assign off_limit = mode.two_line ? char_lcd_pkg::LINE_LAST : char_lcd_pkg::LAST_INDEX;
  wrap_step #(.W(7)) u_offset_step (
    .value_in (offset),
    .limit_in (off_limit),
    .step_in  (off_step),
    .up_in    (off_up),
    .next_out (off_stepped)
  );

  // Address conversions between the printed address space and the linear store index.
  always_comb begin
    set_idx = cmd_byte[6:0];
    if (mode.two_line) begin
      set_idx = (cmd_byte[5:0] > 6'(char_lcd_pkg::LINE_LAST)) ? char_lcd_pkg::LINE_LAST : {1'b0, cmd_byte[5:0]};
      if (cmd_byte[6]) begin
        set_idx = 7'(set_idx + char_lcd_pkg::LINE_LEN);
      end
    end else if (cmd_byte[6:0] > char_lcd_pkg::LAST_INDEX) begin
      set_idx = char_lcd_pkg::LAST_INDEX;
    end
    cursor_address = addr_idx;
    if (mode.two_line && addr_idx >= char_lcd_pkg::LINE_LEN) begin
      cursor_address = 7'(addr_idx - char_lcd_pkg::LINE_LEN + char_lcd_pkg::LINE2_BASE);
    end
  end

  // Visible position to store index; a line's columns wrap inside that line only.
  always_comb begin
    view_sum = 8'(view_pos + offset);
    view_idx = 7'(view_sum);
    if (mode.two_line) begin
      view_sum = (view_pos >= char_lcd_pkg::LINE_LEN) ? 8'(view_pos - char_lcd_pkg::LINE_LEN + offset) : view_sum;
      while_free: begin
        if (view_sum >= 8'(char_lcd_pkg::LINE_LEN)) view_sum = 8'(view_sum - char_lcd_pkg::LINE_LEN);
        if (view_sum >= 8'(char_lcd_pkg::LINE_LEN)) view_sum = 8'(view_sum - char_lcd_pkg::LINE_LEN);
      end
      view_idx = (view_pos >= char_lcd_pkg::LINE_LEN) ? 7'(view_sum + char_lcd_pkg::LINE_LEN) : 7'(view_sum);
    end else if (view_sum > 8'(char_lcd_pkg::LAST_INDEX)) begin
      view_idx = 7'(view_sum - 8'(char_lcd_pkg::RAM_DEPTH));
    end
  end

  // Host byte assembly and instruction decode. Reads carry no busy flag here and are ignored.
  always_comb begin
    next_state          = state;
    next_mode           = mode;
    next_addr_idx       = addr_idx;
    next_offset         = offset;
    next_clear_idx      = clear_idx;
    next_nibble_pending = nibble_pending;
    next_upper_nibble   = upper_nibble;
    addr_step           = 1'b0;
    addr_up             = 1'b1;
    off_step            = 1'b0;
    off_up              = 1'b1;
    ram_we              = 1'b0;
    ram_idx             = addr_idx;
    ram_wdata           = access.data;
    host_go             = access_valid && !access.read && (state == ST_RUN);
    byte_go             = 1'b0;
    cmd_byte            = access.data;
    if (host_go) begin
      if (mode.byte_wide) begin
        byte_go = 1'b1;
      end else if (!nibble_pending) begin
        next_upper_nibble   = access.data[7:4];
        next_nibble_pending = 1'b1;
      end else begin
        cmd_byte            = {upper_nibble, access.data[7:4]};
        byte_go             = 1'b1;
        next_nibble_pending = 1'b0;
      end
    end
    if (byte_go && access.cds) begin
      ram_we    = 1'b1;
      ram_wdata = cmd_byte;
      addr_step = 1'b1;
      addr_up   = mode.increment;
      off_step  = mode.entry_shift;
      off_up    = mode.increment;
    end else if (byte_go) begin
      if (cmd_byte[7]) begin
        next_addr_idx = set_idx;
      end else if (cmd_byte[6]) begin
        next_addr_idx = addr_idx;
      end else if (cmd_byte[5]) begin
        next_mode.byte_wide = cmd_byte[char_lcd_pkg::FS_WIDTH_BIT];
        next_mode.two_line  = cmd_byte[char_lcd_pkg::FS_LINES_BIT];
      end else if (cmd_byte[4]) begin
        addr_step = !cmd_byte[char_lcd_pkg::SH_DISPLAY_BIT];
        addr_up   = cmd_byte[char_lcd_pkg::SH_RIGHT_BIT];
        off_step  = cmd_byte[char_lcd_pkg::SH_DISPLAY_BIT];
        off_up    = !cmd_byte[char_lcd_pkg::SH_RIGHT_BIT];
      end else if (cmd_byte[3]) begin
        next_mode.display_on = cmd_byte[char_lcd_pkg::DC_DISPLAY_BIT];
        next_mode.cursor_on  = cmd_byte[char_lcd_pkg::DC_CURSOR_BIT];
        next_mode.blink      = cmd_byte[char_lcd_pkg::DC_BLINK_BIT];
      end else if (cmd_byte[2]) begin
        next_mode.increment   = cmd_byte[char_lcd_pkg::EM_INC_BIT];
        next_mode.entry_shift = cmd_byte[char_lcd_pkg::EM_SHIFT_BIT];
      end else if (cmd_byte[1]) begin
        next_addr_idx = '0;
        next_offset   = '0;
      end else if (cmd_byte[0]) begin
        next_addr_idx  = '0;
        next_offset    = '0;
        next_clear_idx = '0;
        next_state     = ST_BLANK;
      end
    end
    if (addr_step) begin
      next_addr_idx = addr_stepped;
    end
    if (off_step) begin
      next_offset = off_stepped;
    end
    // The blanking sweep owns the store write port until it is done.
    if (state == ST_BLANK) begin
      ram_we         = 1'b1;
      ram_idx        = clear_idx;
      ram_wdata      = char_lcd_pkg::BLANK_CODE;
      next_clear_idx = 7'(clear_idx + 1'b1);
      if (clear_idx == char_lcd_pkg::LAST_INDEX) begin
        next_state = ST_RUN;
      end
    end
    // A software restart wins over everything the host does in the same cycle.
    if (apb_commit && paddr_in == char_lcd_pkg::REG_CONTROL && pwdata_in[char_lcd_pkg::CTRL_RESTART_BIT]) begin
      next_state          = ST_BLANK;
      next_mode           = MODE_RESET;
      next_addr_idx       = '0;
      next_offset         = '0;
      next_clear_idx      = '0;
      next_nibble_pending = 1'b0;
    end
  end

  // APB slave: one wait cycle, data and error registered with pready.
  always_comb begin
    apb_access    = psel_in && penable_in;
    apb_commit    = apb_access && pready_out && pwrite_in;
    next_pready   = apb_access && !pready_out;
    next_prdata   = '0;
    next_pslverr  = 1'b0;
    next_view_pos = view_pos;
    if (next_pready) begin
      if (paddr_in == char_lcd_pkg::REG_STATUS) begin
        next_prdata[6:0] = {mode.entry_shift, mode.increment, mode.two_line, mode.byte_wide,
                            mode.blink, mode.cursor_on, mode.display_on};
        next_prdata[char_lcd_pkg::STAT_PENDING_BIT] = nibble_pending;
        next_prdata[char_lcd_pkg::STAT_BLANK_BIT]   = (state == ST_BLANK);
      end else if (paddr_in == char_lcd_pkg::REG_POSITION) begin
        next_prdata[6:0] = cursor_address;
        next_prdata[char_lcd_pkg::POS_OFFSET_LSB +: 7] = offset;
      end else if (paddr_in == char_lcd_pkg::REG_VIEW_POS) begin
        next_prdata[6:0] = view_pos;
      end else if (paddr_in == char_lcd_pkg::REG_VIEW_DATA) begin
        next_prdata[7:0] = text_ram[view_idx];
      end else if (paddr_in != char_lcd_pkg::REG_CONTROL) begin
        next_pslverr = 1'b1;
      end
    end
    if (apb_commit && paddr_in == char_lcd_pkg::REG_VIEW_POS) begin
      next_view_pos = (pwdata_in[6:0] > char_lcd_pkg::LAST_INDEX) ? char_lcd_pkg::LAST_INDEX : pwdata_in[6:0];
    end
  end

  // State registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state          <= ST_BLANK;
      mode           <= MODE_RESET;
      addr_idx       <= '0;
      offset         <= '0;
      clear_idx      <= '0;
      view_pos       <= '0;
      nibble_pending <= 1'b0;
      upper_nibble   <= '0;
      prdata_out     <= '0;
      pready_out     <= 1'b0;
      pslverr_out    <= 1'b0;
    end else begin
      state          <= next_state;
      mode           <= next_mode;
      addr_idx       <= next_addr_idx;
      offset         <= next_offset;
      clear_idx      <= next_clear_idx;
      view_pos       <= next_view_pos;
      nibble_pending <= next_nibble_pending;
      upper_nibble   <= next_upper_nibble;
      prdata_out     <= next_prdata;
      pready_out     <= next_pready;
      pslverr_out    <= next_pslverr;
    end
  end

  // The text store has no reset; the blanking sweep fills it instead, which keeps reset fan-out small.
  always_ff @(posedge clk_in) begin
    if (ram_we) begin
      text_ram[ram_idx] <= ram_wdata;
    end
  end

  assign display_on_out     = mode.display_on;
  assign cursor_on_out      = mode.cursor_on;
  assign cursor_index_out   = addr_idx;
  assign display_offset_out = offset;

  // Checks of the instruction behaviour.
  AST_RESET_DEFAULTS: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> mode.byte_wide && !nibble_pending && !mode.display_on && state == ST_BLANK)
    else $error("Reset defaults wrong.");
  AST_NIBBLE_HALF: assert property (@(posedge clk_in) disable iff (rst_in)
    host_go && !mode.byte_wide && !nibble_pending |=> nibble_pending && mode == $past(mode) && addr_idx == $past(addr_idx))
    else $error("First nibble acted on.");
  AST_FUNCSET_WIDTH: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && !access.cds && cmd_byte[7:5] == 3'b001 |=> mode.byte_wide == $past(cmd_byte[4]))
    else $error("Function set width wrong.");
  AST_DISPLAY_CTRL: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && !access.cds && cmd_byte[7:3] == 5'b00001 |=> mode.display_on == $past(cmd_byte[2])
    && mode.cursor_on == $past(cmd_byte[1]))
    else $error("Display control wrong.");
  AST_DATA_INC: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && access.cds && mode.increment && addr_idx != char_lcd_pkg::LAST_INDEX && next_state == ST_RUN
    |=> addr_idx == 7'($past(addr_idx) + 1'b1))
    else $error("Write did not increment.");
  AST_NO_SHIFT_OFFSET: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && access.cds && !mode.entry_shift && next_state == ST_RUN |=> $stable(offset))
    else $error("Offset moved without shift.");
  AST_DATA_STORED: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && access.cds && next_state == ST_RUN |=> text_ram[$past(addr_idx)] == $past(cmd_byte))
    else $error("Data not stored.");
  AST_HOME: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && !access.cds && cmd_byte[7:1] == 7'h01 |=> addr_idx == '0 && offset == '0)
    else $error("Return home failed.");
  AST_LINE_WRAP: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && access.cds && mode.two_line && mode.increment && addr_idx == char_lcd_pkg::LINE_LAST
    && next_state == ST_RUN |=> cursor_address == char_lcd_pkg::LINE2_BASE)
    else $error("No wrap to line two.");
  AST_CURSOR_LEFT: assert property (@(posedge clk_in) disable iff (rst_in)
    byte_go && !access.cds && cmd_byte[7:2] == 6'b000100 && next_state == ST_RUN |=> $stable(offset)
    && addr_idx == (($past(addr_idx) == '0) ? char_lcd_pkg::LAST_INDEX : 7'($past(addr_idx) - 1'b1)))
    else $error("Cursor left wrong.");
  AST_BLANK_LENGTH: assert property (@(posedge clk_in) disable iff (rst_in)
    state == ST_BLANK && clear_idx == char_lcd_pkg::LAST_INDEX && next_state != ST_BLANK ##1 1'b1
    |-> state == ST_RUN && text_ram[char_lcd_pkg::LAST_INDEX] == char_lcd_pkg::BLANK_CODE)
    else $error("Blanking sweep wrong.");
  AST_APB_ONE_WAIT: assert property (@(posedge clk_in) disable iff (rst_in)
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("APB answer timing wrong.");
endmodule : char_lcd_instruction_sequencer
`default_nettype wire

// ===== tb/host_model.sv
// Host controller model for the parallel strobe bus of the display sequencer.
// Assumes the sequencer takes the lines on the strobe falling step and acts a few cycles later.
`default_nettype none
module host_model (
  input  wire logic       clk_in,
  output logic            strobe_out,
  output logic            cds_out,
  output logic            rw_out,
  output logic      [7:0] lines_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nib = 1'b0;
  initial begin
    strobe_out = 1'b0;
    cds_out    = 1'b0;
    rw_out     = 1'b0;
    lines_out  = 8'h00;
  end
  // One strobe access; lines stay put across the falling step, then show their inverse.
  // The select line marks every byte as command or data, the job a control byte does on a serial host.
  task access(input logic c, input logic [7:0] v, input logic r);
    @(posedge clk_in);
    strobe_out <= 1'b1;
    cds_out    <= c;
    rw_out     <= r;
    lines_out  <= v;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    @(posedge clk_in);
    cds_out    <= ~c;
    rw_out     <= 1'b0;
    lines_out  <= ~v;
    repeat (3) @(posedge clk_in);
  endtask : access
  // A byte goes out whole in byte mode, upper nibble first in nibble mode.
  task put(input logic c, input logic [7:0] b);
    if (nib) begin
      access(c, {b[7:4], 4'h0}, 1'b0);
      access(c, {b[3:0], 4'h0}, 1'b0);
    end else begin
      access(c, b, 1'b0);
    end
  endtask : put
  // Start-up by instruction, for a supply that the power-on reset cannot be trusted with.
  task init_seq();
    nib = 1'b0;
    repeat (3) put(1'b0, 8'h30);
    put(1'b0, 8'h38);
  endtask : init_seq
endmodule : host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the display instruction sequencer.
// Assumes the host model on the strobe bus and an APB master task in this module.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, perr, pslverr, dsp, cur;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [6:0] idx, ofs;
  logic strobe, cds, rw;
  logic [7:0] lines;
  int mismatches = 0;
  int num_checks = 0;
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  host_model host_model_i (.clk_in(clk_in), .strobe_out(strobe), .cds_out(cds), .rw_out(rw), .lines_out(lines));
  char_lcd_instruction_sequencer char_lcd_instruction_sequencer_i (.clk_in(clk_in), .rst_in(rst_in),
    .strobe_in(strobe), .command_data_select_in(cds), .read_write_in(rw), .host_bus_lines_in(lines),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .display_on_out(dsp),
    .cursor_on_out(cur), .cursor_index_out(idx), .display_offset_out(ofs));
  task stop_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // APB transfer held until pready is seen at a rising edge; bounded wait.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  task t_reset();
    chk({30'h0, dsp, cur}, 32'h0);
    chk({18'h0, idx, ofs}, 32'h0);
    repeat (90) @(posedge clk_in);
    apb(1'b0, char_lcd_pkg::REG_STATUS, 32'h0);
    chk({23'h0, q[8:0]}, 32'h028);
    apb(1'b1, char_lcd_pkg::REG_VIEW_POS, 32'h0);
    apb(1'b0, char_lcd_pkg::REG_VIEW_DATA, 32'h0);
    chk({24'h0, q[7:0]}, {24'h0, char_lcd_pkg::BLANK_CODE});
  endtask : t_reset
  task t_nibble();
    host_model_i.put(1'b0, 8'h20);
    host_model_i.nib = 1'b1;
    host_model_i.put(1'b0, 8'h28);
    apb(1'b0, char_lcd_pkg::REG_STATUS, 32'h0);
    chk({23'h0, q[8:0]}, 32'h030);
    host_model_i.access(1'b0, 8'h00, 1'b0);
    chk({31'h0, dsp}, 32'h0);
    host_model_i.access(1'b0, 8'he0, 1'b0);
    chk({30'h0, dsp, cur}, 32'h3);
  endtask : t_nibble
  task t_entry();
    host_model_i.put(1'b0, 8'h06);
    host_model_i.put(1'b1, 8'h50);
    host_model_i.put(1'b1, 8'h48);
    chk({18'h0, idx, ofs}, {18'h0, 7'h02, 7'h00});
    host_model_i.put(1'b0, 8'h10);
    chk({18'h0, idx, ofs}, {18'h0, 7'h01, 7'h00});
    host_model_i.put(1'b0, 8'h07);
    host_model_i.put(1'b1, 8'h48);
    chk({18'h0, idx, ofs}, {18'h0, 7'h02, 7'h01});
    host_model_i.put(1'b0, 8'h02);
    chk({18'h0, idx, ofs}, 32'h0);
    apb(1'b0, char_lcd_pkg::REG_VIEW_DATA, 32'h0);
    chk({24'h0, q[7:0]}, 32'h50);
  endtask : t_entry
  task t_wrap();
    host_model_i.put(1'b0, 8'h06);
    host_model_i.put(1'b0, 8'ha7);
    chk({25'h0, idx}, {25'h0, char_lcd_pkg::LINE_LAST});
    host_model_i.put(1'b1, 8'h41);
    chk({25'h0, idx}, {25'h0, char_lcd_pkg::LINE_LEN});
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, perr}, 32'h1);
  endtask : t_wrap
  // Both lines wrap inside themselves; line two column one must still show line two's text.
  task t_shift();
    host_model_i.put(1'b1, 8'h5a);
    host_model_i.put(1'b0, 8'h02);
    host_model_i.put(1'b0, 8'h18);
    chk({18'h0, idx, ofs}, {18'h0, 7'h00, 7'h01});
    host_model_i.put(1'b0, 8'h1c);
    host_model_i.put(1'b0, 8'h1c);
    chk({18'h0, idx, ofs}, {18'h0, 7'h00, char_lcd_pkg::LINE_LAST});
    apb(1'b1, char_lcd_pkg::REG_VIEW_POS, 32'h29);
    apb(1'b0, char_lcd_pkg::REG_VIEW_DATA, 32'h0);
    chk({24'h0, q[7:0]}, 32'h5a);
  endtask : t_shift
  // A software restart in mid-run, host traffic while blanking, then start-up by instruction.
  task t_restart();
    apb(1'b1, char_lcd_pkg::REG_CONTROL, 32'h1);
    host_model_i.nib = 1'b0;
    host_model_i.access(1'b1, 8'h33, 1'b0);
    chk({25'h0, idx}, 32'h0);
    apb(1'b0, char_lcd_pkg::REG_STATUS, 32'h0);
    chk({23'h0, q[8:0]}, 32'h128);
    repeat (90) @(posedge clk_in);
    host_model_i.init_seq();
    apb(1'b0, char_lcd_pkg::REG_STATUS, 32'h0);
    chk({23'h0, q[8:0]}, 32'h038);
    host_model_i.access(1'b0, 8'h0c, 1'b1);
    chk({31'h0, dsp}, 32'h0);
  endtask : t_restart
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    t_reset();
    t_nibble();
    t_entry();
    t_wrap();
    t_shift();
    t_restart();
    stop_test();
  end
endmodule : tb
`default_nettype wire
